// file: ofra_defines.svh
`ifndef OFRA_DEFINES_SVH
`define OFRA_DEFINES_SVH
// First byte of each command pair
`define OFRA_STATUS_READ_CMD 8'h05
`define OFRA_CFG_READ_CMD 8'h15
`define OFRA_STATUS_WRITE_CMD 8'h01
`define OFRA_SECURITY_REG_READ_CMD 8'h2B
`define OFRA_SECURITY_REG_WRITE_CMD 8'h2F
`define OFRA_BOOT_REG_READ_CMD 8'h16
`define OFRA_BOOT_REG_WRITE_CMD 8'h17
`define OFRA_BOOT_REG_ERASE_CMD 8'h18
`define OFRA_WRITE_UNLOCK_CMD 8'h06
`define OFRA_RESET_ARM_CMD 8'h66
`define OFRA_MEM_RESET_CMD 8'h99
`define OFRA_PAGE_PROGRAM_CMD 8'h12
`define OFRA_SECTOR_ERASE_CMD 8'h21
`define OFRA_CHIP_ERASE_CMD 8'h60
`define OFRA_CHIP_ERASE_ALT_CMD 8'hC7
// Register select carried in the last address byte
`define OFRA_SEL_STATUS 8'h00
`define OFRA_SEL_CFG 8'h01
// Status and security field positions
`define OFRA_BUSY_BIT 0
`define OFRA_LATCH_BIT 1
`define OFRA_PROT_LSB 2
`define OFRA_PROT_MSB 5
`define OFRA_SEC_LOCK_BIT 1
// Reset values
`define OFRA_PROT_RST 4'h0
`define OFRA_CFG_RST 8'h07
`define OFRA_SEC_RST 8'h00
`define OFRA_BOOT_RST 32'hFFFFFFFF
// Frame layout, in link clock periods
`define OFRA_CMD_BYTES 4'h2
`define OFRA_ADDR_BYTES 4'h4
`define OFRA_DUMMY_CYC 4'h4
`define OFRA_DATA_START 4'hA
`define OFRA_WR_START 4'h6
// Timing
`define OFRA_SYS_MHZ 50
`define OFRA_BUSY_NS 2000
`define OFRA_BUSY_CYC ((`OFRA_BUSY_NS * `OFRA_SYS_MHZ + 999) / 1000)
`define OFRA_SCK_HALF_NS 40
`define OFRA_SCK_HALF_CYC ((`OFRA_SCK_HALF_NS * `OFRA_SYS_MHZ) / 1000)
`endif

// file: ofra_pkg.sv
`default_nettype none
`include "ofra_defines.svh"
package ofra_pkg;
  // Host sequencer states
  typedef enum logic [1:0] {HS_IDLE, HS_RUN, HS_GAP} ofra_host_e;

  // Commands that return data after the dummy period
  function automatic logic ofra_is_read(input logic [7:0] op);
    return op == `OFRA_STATUS_READ_CMD || op == `OFRA_CFG_READ_CMD ||
           op == `OFRA_SECURITY_REG_READ_CMD ||
           op == `OFRA_BOOT_REG_READ_CMD;
  endfunction : ofra_is_read

  // Commands followed by four address bytes
  function automatic logic ofra_has_addr(input logic [7:0] op);
    return ofra_is_read(op) || op == `OFRA_STATUS_WRITE_CMD ||
           op == `OFRA_BOOT_REG_WRITE_CMD ||
           op == `OFRA_PAGE_PROGRAM_CMD || op == `OFRA_SECTOR_ERASE_CMD;
  endfunction : ofra_has_addr

  // Data bytes the host sends
  function automatic logic [3:0] ofra_wr_len(input logic [7:0] op);
    if (op == `OFRA_BOOT_REG_WRITE_CMD) return 4'h4;
    if (op == `OFRA_STATUS_WRITE_CMD || op == `OFRA_PAGE_PROGRAM_CMD)
      return 4'h1;
    return 4'h0;
  endfunction : ofra_wr_len

  // Program and erase class, gated by the write latch
  function automatic logic ofra_is_pe(input logic [7:0] op);
    return op == `OFRA_PAGE_PROGRAM_CMD || op == `OFRA_SECTOR_ERASE_CMD ||
           op == `OFRA_CHIP_ERASE_CMD || op == `OFRA_CHIP_ERASE_ALT_CMD ||
           op == `OFRA_BOOT_REG_WRITE_CMD || op == `OFRA_BOOT_REG_ERASE_CMD;
  endfunction : ofra_is_pe

  // Codes this pair of ends understands
  function automatic logic ofra_known(input logic [7:0] op);
    return ofra_has_addr(op) || ofra_is_pe(op) ||
           op == `OFRA_SECURITY_REG_WRITE_CMD ||
           op == `OFRA_WRITE_UNLOCK_CMD || op == `OFRA_RESET_ARM_CMD ||
           op == `OFRA_MEM_RESET_CMD;
  endfunction : ofra_known

  // Link period whose byte completes the command
  function automatic logic [3:0] ofra_fire_idx(input logic [7:0] op);
    if (op == `OFRA_BOOT_REG_WRITE_CMD) return `OFRA_DATA_START - 4'h1;
    if (op == `OFRA_STATUS_WRITE_CMD || op == `OFRA_PAGE_PROGRAM_CMD)
      return `OFRA_WR_START;
    if (op == `OFRA_SECTOR_ERASE_CMD) return `OFRA_WR_START - 4'h1;
    return `OFRA_CMD_BYTES - 4'h1;
  endfunction : ofra_fire_idx

  // Protect level p shields the top 2**(p-1) 64 KB blocks
  function automatic logic ofra_prot_hit(input logic [3:0] p,
                                         input logic [31:0] a);
    return (p != 4'h0) &&
           ({6'h00, ~a[25:16]} < (16'h0001 << (p - 4'h1)));
  endfunction : ofra_prot_hit
endpackage : ofra_pkg
`default_nettype wire

// file: ofra_link_if.sv
`timescale 1ns/1ps
`default_nettype none
// Eight-line link; the shared data wire is resolved from the enables
interface ofra_link_if;
  logic sck;        // Link clock, made by the host
  logic cs_n;       // Frame select, low during a frame
  logic [7:0] h_dq_o;  // Host drive value
  logic h_dq_oe;    // Host drives the data lines
  logic [7:0] d_dq_o;  // Device drive value
  logic d_dq_oe;    // Device drives the data lines
  logic [7:0] dq;   // Level seen on the wire, pulled high when idle
  assign dq = h_dq_oe ? h_dq_o : (d_dq_oe ? d_dq_o : 8'hFF);
  modport host (output sck, output cs_n, output h_dq_o,
                output h_dq_oe, input dq);
  modport dev (input sck, input cs_n, input dq,
               output d_dq_o, output d_dq_oe);
endinterface : ofra_link_if
`default_nettype wire

// file: ofra_evt_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Turns a toggle from another clock into a one-cycle pulse
module ofra_evt_sync (
  input wire logic dst_clk,
  input wire logic reset,
  input wire logic tgl_in,
  output logic pulse_out
);
  logic s1_ff;  // First stage, read only by s2_ff
  logic s2_ff;  // Settled copy
  logic s3_ff;  // Previous settled copy for edge detect

  // Two-stage synchroniser plus history
  always_ff @(posedge dst_clk) begin
    if (reset) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end else begin
      s1_ff <= tgl_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Either edge of the toggle is one event
  assign pulse_out = s2_ff ^ s3_ff;
endmodule : ofra_evt_sync
`default_nettype wire

// file: ofra_host_ctl.sv
`timescale 1ns/1ps
`default_nettype none
`include "ofra_defines.svh"
// Host end: frames user commands onto the link
module ofra_host_ctl (
  input wire logic sys_clk,
  input wire logic reset,
  ofra_link_if.host link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [7:0] cmd_op,
  input wire logic [31:0] cmd_addr,
  input wire logic [31:0] cmd_wdata,
  input wire logic [2:0] cmd_rd_len,
  input wire logic dtr_mode,
  output logic rsp_valid,
  output logic [31:0] rsp_data,
  output logic rsp_err,
  output logic idle_seen
);
  import ofra_pkg::*;

  ofra_pkg::ofra_host_e st_ff;  // Sequencer state
  logic [3:0] tmr_ff;  // Half-period timer
  logic sck_ff;        // Divided link clock
  logic cs_n_ff;       // Frame select
  logic [3:0] k_ff;    // Link period in frame
  logic [3:0] total_ff;  // Periods in frame
  logic [3:0] nout_ff;   // Periods the host drives
  logic rd_ff;         // Frame returns data
  logic stat_rd_ff;    // Frame reads the status byte
  logic [79:0] tx_ff;  // Bytes still to send, first in top
  logic [7:0] dq_o_ff;
  logic dq_oe_ff;
  logic [7:0] dq_s1_ff;  // Pin synchroniser, first stage
  logic [7:0] dq_s2_ff;
  logic [31:0] rdata_ff;
  logic ready_ff, rsp_valid_ff, rsp_err_ff, idle_ff;
  logic tick, take, bad, fall, rise;
  logic [3:0] nxt_total, nxt_nout, len;
  logic [31:0] adr, wsh;

  assign tick = tmr_ff == 4'(`OFRA_SCK_HALF_CYC - 1);
  assign take = cmd_valid && ready_ff && ofra_known(cmd_op);
  assign bad = cmd_valid && ready_ff && !ofra_known(cmd_op);
  assign fall = st_ff == HS_RUN && tick && sck_ff;
  assign rise = st_ff == HS_RUN && tick && !sck_ff;

  // Frame shape from the command code
  always_comb begin
    len = (cmd_rd_len == 3'h0) ? 4'h1 : {1'b0, cmd_rd_len};
    if (len > 4'h4) len = 4'h4;
    nxt_nout = `OFRA_CMD_BYTES + ofra_wr_len(cmd_op) +
               (ofra_has_addr(cmd_op) ? `OFRA_ADDR_BYTES : 4'h0);
    nxt_total = ofra_is_read(cmd_op) ?
                `OFRA_DATA_START + len : nxt_nout;
    adr = {cmd_addr[31:1], cmd_addr[0] & !dtr_mode};
    wsh = cmd_wdata << {4'h4 - ofra_wr_len(cmd_op), 3'b000};
  end

  // Sequencer and link clock divider
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_ff <= HS_IDLE;
      tmr_ff <= 4'h0;
      sck_ff <= 1'b0;
      cs_n_ff <= 1'b1;
      k_ff <= 4'h0;
      ready_ff <= 1'b1;
    end else begin
      unique case (st_ff)
        HS_IDLE: begin
          tmr_ff <= 4'h0;
          if (take) begin
            st_ff <= HS_RUN;
            cs_n_ff <= 1'b0;
            k_ff <= 4'h0;
            ready_ff <= 1'b0;
          end
        end
        HS_RUN: begin
          tmr_ff <= tick ? 4'h0 : tmr_ff + 4'h1;
          if (tick) sck_ff <= !sck_ff;
          if (fall) begin
            k_ff <= k_ff + 4'h1;
            if (k_ff + 4'h1 == total_ff) begin
              st_ff <= HS_GAP;
              cs_n_ff <= 1'b1;
            end
          end
        end
        HS_GAP: begin
          tmr_ff <= tick ? 4'h0 : tmr_ff + 4'h1;
          if (tick) begin
            st_ff <= HS_IDLE;
            ready_ff <= 1'b1;
          end
        end
        // Unused state code falls back to idle
        default: st_ff <= HS_IDLE;
      endcase
    end
  end

  // Byte stream: command, complement, address, write data
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      dq_oe_ff <= 1'b0;
      dq_o_ff <= 8'h00;
      tx_ff <= 80'h0;
      total_ff <= 4'h0;
      nout_ff <= 4'h0;
      rd_ff <= 1'b0;
      stat_rd_ff <= 1'b0;
    end else if (take) begin
      total_ff <= nxt_total;
      nout_ff <= nxt_nout;
      rd_ff <= ofra_is_read(cmd_op);
      stat_rd_ff <= cmd_op == `OFRA_STATUS_READ_CMD &&
                    cmd_addr[7:0] == `OFRA_SEL_STATUS;
      dq_oe_ff <= 1'b1;
      dq_o_ff <= cmd_op;
      tx_ff <= ofra_has_addr(cmd_op) ? {cmd_op, ~cmd_op, adr, wsh}
                                     : {cmd_op, ~cmd_op, 64'h0};
    end else if (fall) begin
      tx_ff <= tx_ff << 8;
      dq_o_ff <= tx_ff[71:64];
      dq_oe_ff <= k_ff + 4'h1 < nout_ff;
    end
  end

  // Read data capture through the pin synchroniser
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      dq_s1_ff <= 8'hFF;
      dq_s2_ff <= 8'hFF;
      rdata_ff <= 32'h0;
    end else begin
      dq_s1_ff <= link.dq;
      dq_s2_ff <= dq_s1_ff;
      if (take) rdata_ff <= 32'h0;
      else if (rise && rd_ff && k_ff >= `OFRA_DATA_START)
        rdata_ff <= {rdata_ff[23:0], dq_s2_ff};
    end
  end

  // Answers; idle_seen wants busy and latch both clear in the same status read
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rsp_valid_ff <= 1'b0;
      rsp_err_ff <= 1'b0;
      rsp_data <= 32'h0;
      idle_ff <= 1'b0;
    end else begin
      rsp_valid_ff <= bad || (st_ff == HS_GAP && tick);
      rsp_err_ff <= bad;
      if (st_ff == HS_GAP && tick) rsp_data <= rdata_ff;
      if (st_ff == HS_GAP && tick && stat_rd_ff)
        idle_ff <= !rdata_ff[`OFRA_BUSY_BIT] &&
                   !rdata_ff[`OFRA_LATCH_BIT];
    end
  end

  assign link.sck = sck_ff;
  assign link.cs_n = cs_n_ff;
  assign link.h_dq_o = dq_o_ff;
  assign link.h_dq_oe = dq_oe_ff;
  assign cmd_ready = ready_ff;
  assign rsp_valid = rsp_valid_ff;
  assign rsp_err = rsp_err_ff;
  assign idle_seen = idle_ff;
endmodule : ofra_host_ctl
`default_nettype wire

// file: ofra_flash_dev.sv
`timescale 1ns/1ps
`default_nettype none
`include "ofra_defines.svh"
// Device end: decodes frames on the link clock, keeps state on sys_clk
module ofra_flash_dev (
  input wire logic sys_clk,
  input wire logic reset,
  ofra_link_if.dev link,
  output logic [7:0] status_out,
  output logic [7:0] cfg_out,
  output logic [7:0] security_out,
  output logic [31:0] boot_out,
  output logic mem_reset_pulse
);
  import ofra_pkg::*;

  // Link domain
  logic [3:0] cnt_ff;     // Link period within frame
  logic fired_ff;         // Frame already raised its event
  logic [7:0] op_ff;      // First command byte
  logic ok_ff;            // Pair check passed
  logic [31:0] addr_ff;   // Address bytes, first in top
  logic [31:0] wdat_ff;   // Write data bytes, first in top
  logic [7:0] dq_o_ff;    // Read data drive
  logic dq_oe_ff;         // Device owns the data lines
  logic tgl_ff;           // Event toggle toward sys_clk
  logic [7:0] ev_op_ff;   // Event payload, held until next event
  logic ev_ok_ff;
  logic [31:0] ev_addr_ff;
  logic [31:0] ev_data_ff;
  logic [55:0] rs1_ff;    // Register image, first stage
  logic [55:0] rs2_ff;    // Register image, settled
  logic pair_now, fire, rd_go;
  logic [31:0] nxt_addr, nxt_wdat, boot_sh;
  logic [1:0] rd_idx;
  logic [7:0] nxt_dq;

  // System domain
  logic busy_ff;          // Volatile busy flag
  logic latch_ff;         // Volatile write latch
  logic [3:0] prot_ff;    // Protect level
  logic [7:0] cfg_ff;
  logic [7:0] sec_ff;
  logic [31:0] boot_ff;
  logic armed_ff;         // Last command was reset arm
  logic [15:0] bcnt_ff;   // Busy time remaining
  logic mrst_ff;
  logic ev, ev_ok, write_unlock_cmd, pe, blocked, go, sw, done, do_rst;

  // Byte complement check on the second period
  assign pair_now = link.dq == ~op_ff;
  // Raise an event once the command is complete, or at a bad pair
  assign fire = !link.cs_n && !fired_ff &&
                ((cnt_ff == 4'h1 && (!pair_now ||
                  ofra_fire_idx(op_ff) == 4'h1)) ||
                 (cnt_ff > 4'h1 && ok_ff &&
                  cnt_ff == ofra_fire_idx(op_ff)));
  // Read data starts after four dummy periods
  assign rd_go = ok_ff && ofra_is_read(op_ff) &&
                 cnt_ff >= `OFRA_DATA_START - 4'h1;

  // Shift address and data as they arrive
  always_comb begin
    nxt_addr = addr_ff;
    nxt_wdat = wdat_ff;
    if (cnt_ff >= `OFRA_CMD_BYTES && cnt_ff < `OFRA_WR_START)
      nxt_addr = {addr_ff[23:0], link.dq};
    if (cnt_ff >= `OFRA_WR_START && cnt_ff < `OFRA_DATA_START)
      nxt_wdat = {wdat_ff[23:0], link.dq};
  end

  // Pick the read byte; boot data goes out first byte on top
  always_comb begin
    rd_idx = 2'(cnt_ff - (`OFRA_DATA_START - 4'h1));
    boot_sh = rs2_ff[55:24] << {rd_idx, 3'b000};
    nxt_dq = 8'h00;
    unique case (op_ff)
      `OFRA_STATUS_READ_CMD, `OFRA_CFG_READ_CMD:
        nxt_dq = (addr_ff[7:0] == `OFRA_SEL_CFG) ?
                 rs2_ff[15:8] : rs2_ff[7:0];
      `OFRA_SECURITY_REG_READ_CMD: nxt_dq = rs2_ff[23:16];
      `OFRA_BOOT_REG_READ_CMD: nxt_dq = boot_sh[31:24];
      default: nxt_dq = 8'h00;
    endcase
  end

  // Frame progress, cleared whenever the frame select is high
  always_ff @(posedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      cnt_ff <= 4'h0;
      fired_ff <= 1'b0;
      ok_ff <= 1'b0;
      dq_oe_ff <= 1'b0;
      dq_o_ff <= 8'h00;
    end else begin
      if (cnt_ff != 4'hF) cnt_ff <= cnt_ff + 4'h1;
      if (fire) fired_ff <= 1'b1;
      if (cnt_ff == 4'h1) ok_ff <= pair_now;
      // One byte per rising edge, also in double-rate frames
      if (rd_go && cnt_ff < `OFRA_DATA_START + 4'h3) begin
        dq_oe_ff <= 1'b1;
        dq_o_ff <= nxt_dq;
      end
    end
  end

  // Frame payload; plain data, so it needs no reset
  always_ff @(posedge link.sck) begin
    if (cnt_ff == 4'h0) op_ff <= link.dq;
    addr_ff <= nxt_addr;
    wdat_ff <= nxt_wdat;
    if (fire) begin
      ev_op_ff <= op_ff;
      ev_ok_ff <= (cnt_ff == 4'h1) ? pair_now : ok_ff;
      ev_addr_ff <= nxt_addr;
      ev_data_ff <= nxt_wdat;
    end
  end

  // Event toggle; payload stays put until the next frame's event
  always_ff @(posedge link.sck or posedge reset) begin
    if (reset) tgl_ff <= 1'b0;
    else if (fire) tgl_ff <= !tgl_ff;
  end

  // Register image into the link domain. Bits may tear if a write
  // lands during a read frame; the next read sees clean values.
  always_ff @(posedge link.sck or posedge reset) begin
    if (reset) begin
      rs1_ff <= 56'h0;
      rs2_ff <= 56'h0;
    end else begin
      rs1_ff <= {boot_ff, sec_ff, cfg_ff, status_out};
      rs2_ff <= rs1_ff;
    end
  end

  ofra_evt_sync u_evt_sync (
    .dst_clk(sys_clk),
    .reset(reset),
    .tgl_in(tgl_ff),
    .pulse_out(ev)
  );

  // Command execution terms
  always_comb begin
    ev_ok = ev && ev_ok_ff;
    write_unlock_cmd = ev_ok && ev_op_ff == `OFRA_WRITE_UNLOCK_CMD;
    pe = ev_ok && ofra_is_pe(ev_op_ff) && latch_ff && !busy_ff;
    blocked = 1'b0;
    if (ev_op_ff == `OFRA_CHIP_ERASE_CMD ||
        ev_op_ff == `OFRA_CHIP_ERASE_ALT_CMD)
      blocked = prot_ff != 4'h0;
    else if (ev_op_ff == `OFRA_PAGE_PROGRAM_CMD ||
             ev_op_ff == `OFRA_SECTOR_ERASE_CMD)
      blocked = ofra_prot_hit(prot_ff, ev_addr_ff);
    go = pe && !blocked;
    sw = ev_ok && ev_op_ff == `OFRA_STATUS_WRITE_CMD &&
         latch_ff && !busy_ff;
    done = busy_ff && bcnt_ff == 16'h0001;
    do_rst = ev_ok && ev_op_ff == `OFRA_MEM_RESET_CMD && armed_ff;
  end

  // Reset pairing: any event but reset arm, even a rejected pair, disarms
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      armed_ff <= 1'b0;
      mrst_ff <= 1'b0;
    end else begin
      if (ev) armed_ff <= ev_ok && ev_op_ff == `OFRA_RESET_ARM_CMD;
      mrst_ff <= do_rst;
    end
  end

  // Busy flag and its timer
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      busy_ff <= 1'b0;
      bcnt_ff <= 16'h0000;
    end else if (go || sw) begin
      busy_ff <= 1'b1;
      bcnt_ff <= 16'(`OFRA_BUSY_CYC);
    end else if (busy_ff) begin
      bcnt_ff <= bcnt_ff - 16'h0001;
      if (done) busy_ff <= 1'b0;
    end
  end

  // Write latch; a set in the cycle of a clear wins
  always_ff @(posedge sys_clk) begin
    if (reset) latch_ff <= 1'b0;
    else if (write_unlock_cmd) latch_ff <= 1'b1;
    else if (done || do_rst) latch_ff <= 1'b0;
    else if (pe && blocked) latch_ff <= 1'b0;
  end

  // Status and configuration writes, selected by last address byte
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      prot_ff <= `OFRA_PROT_RST;
      cfg_ff <= `OFRA_CFG_RST;
    end else if (sw) begin
      if (ev_addr_ff[7:0] == `OFRA_SEL_STATUS)
        prot_ff <= ev_data_ff[`OFRA_PROT_MSB:`OFRA_PROT_LSB];
      else if (ev_addr_ff[7:0] == `OFRA_SEL_CFG)
        cfg_ff <= ev_data_ff[7:0];
    end else if (do_rst) begin
      cfg_ff <= `OFRA_CFG_RST;
    end
  end

  // Security and boot registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sec_ff <= `OFRA_SEC_RST;
      boot_ff <= `OFRA_BOOT_RST;
    end else begin
      if (ev_ok && ev_op_ff == `OFRA_SECURITY_REG_WRITE_CMD)
        sec_ff[`OFRA_SEC_LOCK_BIT] <= 1'b1;
      if (go && ev_op_ff == `OFRA_BOOT_REG_WRITE_CMD)
        boot_ff <= ev_data_ff;
      if (go && ev_op_ff == `OFRA_BOOT_REG_ERASE_CMD)
        boot_ff <= `OFRA_BOOT_RST;
    end
  end

  assign status_out = {2'b00, prot_ff, latch_ff, busy_ff};
  assign cfg_out = cfg_ff;
  assign security_out = sec_ff;
  assign boot_out = boot_ff;
  assign mem_reset_pulse = mrst_ff;
  assign link.d_dq_o = dq_o_ff;
  assign link.d_dq_oe = dq_oe_ff;
endmodule : ofra_flash_dev
`default_nettype wire

// file: ofra_link_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// Watches the link from sys_clk; sck is sampled as plain data
module ofra_link_asserts (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic h_dq_oe,
  input wire logic d_dq_oe,
  input wire logic [7:0] dq
);
  logic sck_ff; // Last sampled link clock
  logic [3:0] idx_ff; // Link rising edges seen in this frame
  logic [7:0] op_ff; // First command byte of the frame
  logic rise; // Link clock rose since the last sample
  logic rd_op; // Frame returns data after the dummy period
  assign rise = sck && !sck_ff;
  assign rd_op = op_ff == 8'h05 || op_ff == 8'h15 || op_ff == 8'h2B ||
                 op_ff == 8'h16;
  // Edge detect on the link clock
  always_ff @(posedge sys_clk) begin
    sck_ff <= reset ? 1'b0 : sck;
  end
  // Period counter, cleared between frames
  always_ff @(posedge sys_clk) begin
    if (reset || cs_n) begin
      idx_ff <= 4'h0;
    end else if (rise) begin
      idx_ff <= idx_ff + 4'h1;
    end
  end
  // First byte kept so the second can be compared with it
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      op_ff <= 8'h00;
    end else if (rise && idx_ff == 4'h0) begin
      op_ff <= dq;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_idle_clock_low: assert property (cs_n |-> !sck)
    else $error("link clock high outside a frame");
  a_idle_lines_free: assert property (
    cs_n && $past(cs_n) |-> !h_dq_oe && !d_dq_oe)
    else $error("data lines driven outside a frame");
  a_no_drive_clash: assert property (!(h_dq_oe && d_dq_oe))
    else $error("both ends drive the data lines");
  a_pair_complement: assert property (
    rise && idx_ff == 4'h1 |-> dq == ~op_ff)
    else $error("second command byte not the complement");
  a_dummy_quiet: assert property (rise && idx_ff <= 4'h8 |-> !d_dq_oe)
    else $error("device drove before the dummy period ended");
  a_host_released: assert property (
    rise && idx_ff >= 4'h6 && rd_op |-> !h_dq_oe)
    else $error("host still drives in the dummy period");
  a_data_phase: assert property (
    rise && idx_ff == 4'hA && rd_op |-> d_dq_oe)
    else $error("read data missing after four dummy periods");
  a_clock_shape: assert property ($rose(sck) |=> sck ##1 !sck)
    else $error("link clock high time wrong");
  a_frame_opens: assert property ($fell(cs_n) |-> h_dq_oe && !sck)
    else $error("frame opened without host drive");
  cover property (rise && idx_ff == 4'hA && rd_op);
  cover property (rise && idx_ff == 4'h9 && !rd_op);
  cover property ($fell(cs_n));
endmodule : ofra_link_asserts
`default_nettype wire

// file: tb_octal_flash_register_access.sv
`timescale 1ns/1ps
`default_nettype none
module tb_octal_flash_register_access;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic cmd_valid = 1'b0;
  logic [7:0] cmd_op = 8'h00;
  logic [31:0] cmd_addr = 32'h0;
  logic [31:0] cmd_wdata = 32'h0;
  logic [2:0] cmd_rd_len = 3'h1;
  logic dtr_mode = 1'b0;
  logic cmd_ready, rsp_valid, rsp_err, idle_seen, mem_reset_pulse;
  logic [31:0] rsp_data, boot_out;
  logic [7:0] status_out, cfg_out, security_out;
  logic last_err; // Error flag of the last answer
  int failures = 0;
  int samples_checked = 0;
  int rst_seen = 0; // Memory reset pulses counted
  ofra_link_if link ();
  ofra_host_ctl ofra_host_ctl_i (.sys_clk(sys_clk), .reset(reset),
    .link(link), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_rd_len(cmd_rd_len), .dtr_mode(dtr_mode), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_err(rsp_err), .idle_seen(idle_seen));
  ofra_flash_dev ofra_flash_dev_i (.sys_clk(sys_clk), .reset(reset),
    .link(link), .status_out(status_out), .cfg_out(cfg_out),
    .security_out(security_out), .boot_out(boot_out),
    .mem_reset_pulse(mem_reset_pulse));
  ofra_link_asserts ofra_link_asserts_i (.sys_clk(sys_clk),
    .reset(reset), .sck(link.sck), .cs_n(link.cs_n),
    .h_dq_oe(link.h_dq_oe), .d_dq_oe(link.d_dq_oe), .dq(link.dq));
  // 50 MHz system clock
  always #10 sys_clk = ~sys_clk;
  // Pulse is one cycle wide, so count it at every rising edge
  always @(posedge sys_clk) begin
    if (mem_reset_pulse === 1'b1) rst_seen++;
  end
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  // One command through the host port; waits for its answer
  task automatic cmd(input logic [7:0] op, input logic [31:0] a = 0,
                     input logic [31:0] d = 0, input logic [2:0] n = 1);
    int k;
    @(negedge sys_clk);
    {cmd_op, cmd_addr, cmd_wdata, cmd_rd_len} = {op, a, d, n};
    cmd_valid = 1'b1;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    k = 0;
    while (rsp_valid !== 1'b1 && k < 300) begin
      @(negedge sys_clk);
      k++;
    end
    if (k >= 300) chk("answer", 32'h0, 32'h1);
    last_err = rsp_err;
    repeat (4) @(negedge sys_clk);
  endtask : cmd
  // Busy lasts 100 cycles; margin added
  task automatic wt;
    repeat (110) @(negedge sys_clk);
  endtask : wt
  task automatic t_reset_values;
    chk("status", {24'h0, status_out}, 32'h00);
    chk("cfg", {24'h0, cfg_out}, 32'h07);
    chk("sec", {24'h0, security_out}, 32'h00);
    chk("boot", boot_out, 32'hFFFFFFFF);
  endtask : t_reset_values
  task automatic t_boot_path;
    cmd(8'h17, 0, 32'h12345678);
    chk("boot locked", boot_out, 32'hFFFFFFFF);
    cmd(8'h06);
    chk("latch", {24'h0, status_out}, 32'h02);
    cmd(8'h17, 0, 32'h12345678);
    chk("busy", {24'h0, status_out}, 32'h03);
    wt();
    chk("done", {24'h0, status_out}, 32'h00);
    chk("boot written", boot_out, 32'h12345678);
    dtr_mode = 1'b1;
    cmd(8'h16, 0, 0, 3'h4);
    chk("boot read4", rsp_data, 32'h12345678);
    cmd(8'h16, 0, 0, 3'h1);
    chk("boot read1", {24'h0, rsp_data[7:0]}, 32'h12);
    dtr_mode = 1'b0;
    cmd(8'h06);
    cmd(8'h18);
    wt();
    chk("boot erased", boot_out, 32'hFFFFFFFF);
  endtask : t_boot_path
  task automatic t_security;
    cmd(8'h2B);
    chk("sec read", {24'h0, rsp_data[7:0]}, 32'h00);
    cmd(8'h2F);
    chk("sec write", {24'h0, security_out}, 32'h02);
    cmd(8'h2B);
    chk("sec reread", {24'h0, rsp_data[7:0]}, 32'h02);
  endtask : t_security
  task automatic t_protect;
    cmd(8'h06);
    cmd(8'h01, 0, 32'h04);
    wt();
    chk("protect set", {24'h0, status_out}, 32'h04);
    cmd(8'h05);
    chk("status read", {24'h0, rsp_data[7:0]}, 32'h04);
    chk("idle", {31'h0, idle_seen}, 32'h1);
    cmd(8'h06);
    cmd(8'h60);
    chk("chip erase held", {31'h0, status_out[0]}, 32'h0);
    cmd(8'h06);
    cmd(8'h21, 32'h03FF0000);
    chk("guarded", {24'h0, status_out}, 32'h04);
    cmd(8'h06);
    cmd(8'h01, 0, 32'h00);
    wt();
    cmd(8'h06);
    cmd(8'h60);
    chk("chip erase", {31'h0, status_out[0]}, 32'h1);
    wt();
  endtask : t_protect
  // Config write and read by select byte; odd address in double rate
  task automatic t_config;
    cmd(8'h06);
    cmd(8'h01, 32'h01, 32'h5A);
    wt();
    chk("cfg write", {24'h0, cfg_out}, 32'h5A);
    cmd(8'h15, 32'h01);
    chk("cfg read", {24'h0, rsp_data[7:0]}, 32'h5A);
    dtr_mode = 1'b1;
    cmd(8'h15, 32'h01);
    chk("even addr", {24'h0, rsp_data[7:0]}, 32'h00);
    dtr_mode = 1'b0;
  endtask : t_config
  task automatic t_reset_pair;
    cmd(8'h66);
    cmd(8'h99);
    chk("reset paired", rst_seen, 32'h1);
    chk("cfg restored", {24'h0, cfg_out}, 32'h07);
    cmd(8'h66);
    cmd(8'h05);
    cmd(8'h99);
    chk("reset split", rst_seen, 32'h1);
    cmd(8'h5A);
    chk("unknown", {31'h0, last_err}, 32'h1);
    chk("ready kept", {31'h0, cmd_ready}, 32'h1);
  endtask : t_reset_pair
  // Whole run is under two thousand cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    report_and_stop();
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    reset = 1'b0;
    t_reset_values();
    t_boot_path();
    t_security();
    t_protect();
    t_config();
    t_reset_pair();
    report_and_stop();
  end
endmodule : tb_octal_flash_register_access
`default_nettype wire
